/* File: verilog/watchdog_control.sv */
// Purpose: watchdog control register, timeout counter and reset cause flags
// Assumes: i_reset is the power-on reset; oscillator, pin reset and fuse are asynchronous
// Notes: registers are reached through the processor byte port at their printed offsets
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - external reset sets external flag; power-on reset or writing zero clears it.
// - power-on reset sets power-on flag; only writing zero clears it.
// - timeout in interrupt operation sets the interrupt flag, control bit 7.
// - interrupt flag clears on vector execution or on writing one to it.
// - interrupt requested only with global enable, interrupt enable and flag all set.
// - fuse unprogrammed: reset-enable/interrupt-enable pick stopped, interrupt, reset, combined.
// - combined mode vector execution clears interrupt enable and flag.
// - combined mode timeout with interrupt still pending gives system reset.
// - fuse programmed forces system-reset mode regardless of enable bits.
// - clearing reset-enable or changing prescaler needs change-enable; it self-clears after four cycles.
// - reset-enable held set while watchdog reset cause flag is set.
// - prescaler code selects 2048 shifted by code oscillator cycles; 10 to 15 reserved.
// - control bits: 7 flag, 6 enable, 5 prescaler3, 4 change, 3 reset, 2:0 prescaler.
// - prescaler applies to the timeout only while the watchdog runs.
// - watchdog system reset sets the watchdog reset cause flag.
// - counter counts cycles of the separate 128 kHz oscillator.
// - restart instruction clears the counter to zero before timeout.
module watchdog_control
    import watchdog_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_osc_clock,
    input wire logic i_external_reset_n,
    input wire logic i_always_on_fuse,
    input wire logic [7:0] i_address,
    input wire logic i_write,
    input wire logic [7:0] i_write_data,
    input wire logic i_read,
    input wire logic i_global_interrupt_enable,
    input wire logic i_vector_executed,
    input wire logic i_restart,
    output logic [7:0] o_read_data,
    output logic o_interrupt_request,
    output logic o_system_reset
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic osc_sync;
    logic ext_n_sync;
    logic fuse_sync;
    logic osc_prev_r;
    logic ext_prev_n_r;

    level_sync #(.RESET_VALUE(1'b0)) u_osc_sync (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_level(i_osc_clock),
        .o_level(osc_sync)
    );
    level_sync #(.RESET_VALUE(1'b1)) u_ext_sync (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_level(i_external_reset_n),
        .o_level(ext_n_sync)
    );
    level_sync #(.RESET_VALUE(1'b1)) u_fuse_sync (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_level(i_always_on_fuse),
        .o_level(fuse_sync)
    );

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            osc_prev_r <= 1'b0;
            ext_prev_n_r <= 1'b1;
        end else begin
            osc_prev_r <= osc_sync;
            ext_prev_n_r <= ext_n_sync;
        end
    end

    logic osc_tick;
    logic ext_reset;
    logic fuse_programmed;
    assign osc_tick = osc_sync & ~osc_prev_r;
    assign ext_reset = ~ext_n_sync;
    assign fuse_programmed = ~fuse_sync;

    // ****************************************
    // state
    // ****************************************
    control_type control_r;
    logic [3:0] cause_r;
    logic [2:0] window_count_r;
    logic [COUNT_WIDTH-1:0] count_r;
    logic wdog_reset;
    logic timeout;
    logic wr_control;
    logic wr_cause;
    control_type wr_value;
    mode_type mode;
    logic eff_reset_enable;
    logic eff_int_enable;

    assign wr_control = i_write && (i_address == CONTROL_STATUS_ADDR);
    assign wr_cause = i_write && (i_address == RESET_CAUSE_ADDR);
    assign wr_value = control_type'(i_write_data);
    assign eff_reset_enable = control_r.reset_enable | cause_r[WATCHDOG_BIT]
        | fuse_programmed;
    assign eff_int_enable = control_r.interrupt_enable & ~fuse_programmed;

    always_comb begin
        unique case ({eff_reset_enable, eff_int_enable})
            2'b00: mode = MODE_STOPPED;
            2'b01: mode = MODE_INTERRUPT;
            2'b10: mode = MODE_RESET;
            2'b11: mode = MODE_COMBINED;
        endcase
    end

    // ****************************************
    // timeout counter
    // ****************************************
    logic [3:0] select;
    logic [COUNT_WIDTH-1:0] limit;
    assign select = (control_r.prescaler_high && control_r.prescaler_low > 3'h1)
        ? LAST_VALID_SELECT : {control_r.prescaler_high, control_r.prescaler_low};
    assign limit = COUNT_WIDTH'((BASE_TIMEOUT_CYCLES << select) - 1);
    assign timeout = (mode != MODE_STOPPED) && osc_tick && (count_r == limit);

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            count_r <= '0;
        end else if (ext_reset || wdog_reset || i_restart || mode == MODE_STOPPED) begin
            count_r <= '0;
        end else if (osc_tick) begin
            count_r <= (count_r >= limit) ? '0 : count_r + 1'b1;
        end
    end

    // ****************************************
    // timeout action
    // ****************************************
    assign wdog_reset = timeout && (mode == MODE_RESET
        || (mode == MODE_COMBINED && control_r.interrupt_flag));

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_system_reset <= 1'b0;
        end else begin
            o_system_reset <= wdog_reset;
        end
    end

    // ****************************************
    // change window
    // ****************************************
    logic window_open;
    assign window_open = control_r.change_enable;

    always_ff @(posedge i_clock) begin
        if (i_reset || ext_reset || wdog_reset) begin
            window_count_r <= '0;
        end else if (wr_control && wr_value.change_enable) begin
            window_count_r <= 3'(CHANGE_WINDOW_CYCLES);
        end else if (window_count_r != '0) begin
            window_count_r <= window_count_r - 1'b1;
        end
    end

    // ****************************************
    // control register
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (i_reset || ext_reset || wdog_reset) begin
            control_r <= control_type'(CONTROL_RESET);
        end else begin
            if (timeout && (mode == MODE_INTERRUPT || mode == MODE_COMBINED)) begin
                control_r.interrupt_flag <= 1'b1;
            end else if (i_vector_executed || (wr_control && wr_value.interrupt_flag)) begin
                control_r.interrupt_flag <= 1'b0;
            end
            if (i_vector_executed && mode == MODE_COMBINED) begin
                control_r.interrupt_enable <= 1'b0;
            end else if (wr_control) begin
                control_r.interrupt_enable <= wr_value.interrupt_enable;
            end
            if (wr_control) begin
                if (window_open) begin
                    control_r.reset_enable <= wr_value.reset_enable;
                    control_r.prescaler_high <= wr_value.prescaler_high;
                    control_r.prescaler_low <= wr_value.prescaler_low;
                end else begin
                    control_r.reset_enable <= control_r.reset_enable
                        | wr_value.reset_enable;
                end
            end
            if (wr_control && wr_value.change_enable) begin
                control_r.change_enable <= 1'b1;
            end else if (window_count_r == 3'h1 || (wr_control && window_open)) begin
                control_r.change_enable <= 1'b0;
            end
        end
    end

    // ****************************************
    // reset cause flags
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            cause_r <= 4'h1;
        end else begin
            cause_r[POWER_ON_BIT] <= cause_r[POWER_ON_BIT]
                & ~(wr_cause & ~i_write_data[POWER_ON_BIT]);
            cause_r[BROWNOUT_BIT] <= 1'b0;
            if (ext_reset && ext_prev_n_r) begin
                cause_r[EXTERNAL_BIT] <= 1'b1;
            end else if (wr_cause && !i_write_data[EXTERNAL_BIT]) begin
                cause_r[EXTERNAL_BIT] <= 1'b0;
            end
            if (wdog_reset) begin
                cause_r[WATCHDOG_BIT] <= 1'b1;
            end else if (wr_cause && !i_write_data[WATCHDOG_BIT]) begin
                cause_r[WATCHDOG_BIT] <= 1'b0;
            end
        end
    end

    // ****************************************
    // read port and interrupt request
    // ****************************************
    control_type control_view;
    always_comb begin
        control_view = control_r;
        control_view.reset_enable = eff_reset_enable;
        control_view.interrupt_enable = eff_int_enable;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_read_data <= 8'h00;
        end else if (i_read && i_address == CONTROL_STATUS_ADDR) begin
            o_read_data <= control_view;
        end else if (i_read && i_address == RESET_CAUSE_ADDR) begin
            o_read_data <= {4'h0, cause_r};
        end else begin
            o_read_data <= 8'h00;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_interrupt_request <= 1'b0;
        end else begin
            o_interrupt_request <= i_global_interrupt_enable & eff_int_enable
                & control_r.interrupt_flag & ~i_vector_executed;
        end
    end
endmodule : watchdog_control
`default_nettype wire

/* File: verilog/watchdog_pkg.sv */
// Purpose: shared constants and types of the watchdog control block
// Assumes: 100 MHz system clock, byte-wide processor register port
// Notes: timeout counts are in watchdog oscillator cycles
package watchdog_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] CONTROL_STATUS_ADDR = 8'h60;
    localparam logic [7:0] RESET_CAUSE_ADDR = 8'h54;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam int POWER_ON_BIT = 0;
    localparam int EXTERNAL_BIT = 1;
    localparam int BROWNOUT_BIT = 2;
    localparam int WATCHDOG_BIT = 3;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLOCK_MHZ = 100;
    localparam int CHANGE_WINDOW_CYCLES = 4;
    localparam int OSC_KHZ = 128;
    localparam int COUNT_WIDTH = 20;
    localparam int BASE_TIMEOUT_CYCLES = 2048;
    localparam logic [3:0] LAST_VALID_SELECT = 4'h9;
    localparam int SYNC_STAGES = 2;
    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic interrupt_flag;
        logic interrupt_enable;
        logic prescaler_high;
        logic change_enable;
        logic reset_enable;
        logic [2:0] prescaler_low;
    } control_type;
    typedef enum {MODE_STOPPED, MODE_INTERRUPT, MODE_RESET, MODE_COMBINED} mode_type;
endpackage : watchdog_pkg

/* File: verilog/level_sync.sv */
// Purpose: two-flop synchroniser for levels arriving from outside the clock domain
// Assumes: input changes slowly relative to the clock
// Notes: first stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module level_sync
    import watchdog_pkg::*;
#(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_level,
    output logic o_level
);
    logic meta_r;
    logic stable_r;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            meta_r <= RESET_VALUE;
            stable_r <= RESET_VALUE;
        end else begin
            meta_r <= i_level;
            stable_r <= meta_r;
        end
    end

    assign o_level = stable_r;
endmodule : level_sync
`default_nettype wire

/* File: testbench/watchdog_control_checker.sv */
// Purpose: port assertions for watchdog_control
// Assumes: one clock domain, synchronous active-high reset
// Notes: attached by the bind after the module
`timescale 1ns/1ns
`default_nettype none
module watchdog_control_checker
    import watchdog_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_always_on_fuse,
    input wire logic [7:0] i_address,
    input wire logic i_write,
    input wire logic [7:0] i_write_data,
    input wire logic i_read,
    input wire logic i_global_interrupt_enable,
    input wire logic i_vector_executed,
    input wire logic [7:0] o_read_data,
    input wire logic o_interrupt_request,
    input wire logic o_system_reset
);
    logic wd_cause_r;
    logic ctl_rd;
    logic ctl_wr;
    assign ctl_rd = i_read && i_address == CONTROL_STATUS_ADDR;
    assign ctl_wr = i_write && i_address == CONTROL_STATUS_ADDR;
    // mirror of the watchdog cause flag
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            wd_cause_r <= 1'b0;
        end else if (o_system_reset) begin
            wd_cause_r <= 1'b1;
        end else if (i_write && i_address == RESET_CAUSE_ADDR && !i_write_data[WATCHDOG_BIT]) begin
            wd_cause_r <= 1'b0;
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);
    AST_IRQ_GLOBAL: assert property (!i_global_interrupt_enable |=> !o_interrupt_request)
        else $error("request without global enable");
    AST_IRQ_VECTOR: assert property (i_vector_executed |=> !o_interrupt_request)
        else $error("request after vector");
    AST_IRQ_WRITE_ONE: assert property (ctl_wr && i_write_data[7] |-> ##2 !o_interrupt_request)
        else $error("request after flag write");
    AST_RST_PULSE: assert property (o_system_reset |=> !o_system_reset)
        else $error("system reset too long");
    AST_FUSE_LOCK: assert property (
        ctl_rd && !i_always_on_fuse && !$past(i_always_on_fuse, 4)
        |=> o_read_data[3] && !o_read_data[6])
        else $error("fuse lock not shown");
    AST_WDE_HELD: assert property (ctl_rd && wd_cause_r |=> o_read_data[3])
        else $error("reset enable dropped");
    AST_WINDOW_OPEN: assert property (
        ctl_wr && i_write_data == 8'h18 ##1 !i_write ##1 ctl_wr && !i_write_data[4] ##2 ctl_rd
        |=> o_read_data[2:0] == $past(i_write_data[2:0], 3))
        else $error("prescaler not changed in window");
    AST_WINDOW_SHUT: assert property (
        ctl_wr && i_write_data == 8'h18 ##1 !i_write [*6] ##1 ctl_wr && !i_write_data[3]
        ##2 ctl_rd |=> o_read_data[3])
        else $error("reset enable cleared outside window");
endmodule : watchdog_control_checker
bind watchdog_control watchdog_control_checker u_chk (.i_clock(i_clock), .i_reset(i_reset),
    .i_always_on_fuse(i_always_on_fuse), .i_address(i_address), .i_write(i_write),
    .i_write_data(i_write_data), .i_read(i_read), .o_read_data(o_read_data),
    .i_global_interrupt_enable(i_global_interrupt_enable), .o_system_reset(o_system_reset),
    .i_vector_executed(i_vector_executed), .o_interrupt_request(o_interrupt_request));
`default_nettype wire

/* File: testbench/watchdog_control_tb_top.sv */
// Purpose: self-checking bench for watchdog_control
// Assumes: oscillator ticks every 8 system clocks
// Notes: reads scored from a queue of masked expectations
`timescale 1ns/1ns
`default_nettype none
module watchdog_control_tb_top
    import watchdog_pkg::*;
;
    localparam logic [7:0] CS = CONTROL_STATUS_ADDR;
    localparam logic [7:0] RC = RESET_CAUSE_ADDR;
    logic i_clock = 1'b0, i_reset = 1'b1, i_osc_clock = 1'b0, i_external_reset_n = 1'b1;
    logic i_always_on_fuse = 1'b1, i_write = 1'b0, i_read = 1'b0, rd_seen = 1'b0;
    logic i_global_interrupt_enable = 1'b0, i_vector_executed = 1'b0, i_restart = 1'b0;
    logic [7:0] i_address = 8'h00, i_write_data = 8'h00, o_read_data, pd;
    logic o_interrupt_request, o_system_reset;
    logic [15:0] exp_q[$];
    logic [15:0] note;
    int n_mismatch = 0, tests_run = 0, rst_cnt = 0, c;
    watchdog_control uut (.i_clock(i_clock), .i_reset(i_reset), .i_osc_clock(i_osc_clock),
        .i_external_reset_n(i_external_reset_n), .i_always_on_fuse(i_always_on_fuse),
        .i_address(i_address), .i_write(i_write), .i_write_data(i_write_data),
        .i_read(i_read), .i_global_interrupt_enable(i_global_interrupt_enable),
        .i_vector_executed(i_vector_executed), .i_restart(i_restart),
        .o_read_data(o_read_data), .o_interrupt_request(o_interrupt_request),
        .o_system_reset(o_system_reset));
    always #5 i_clock = ~i_clock;
    always begin
        repeat (4) @(posedge i_clock);
        i_osc_clock <= ~i_osc_clock;
    end
    task automatic test_done;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_write <= 1'b1;
        i_address <= a;
        i_write_data <= d;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge i_clock);
        exp_q.push_back({m, e});
        i_read <= 1'b1;
        i_address <= a;
        @(posedge i_clock);
        i_read <= 1'b0;
    endtask : rd
    task automatic restart;
        @(posedge i_clock);
        i_restart <= 1'b1;
        @(posedge i_clock);
        i_restart <= 1'b0;
    endtask : restart
    task automatic vec;
        @(posedge i_clock);
        i_vector_executed <= 1'b1;
        @(posedge i_clock);
        i_vector_executed <= 1'b0;
        @(negedge i_clock);
        chk(o_interrupt_request === 1'b0, "request stays after vector");
    endtask : vec
    task automatic ext_rst;
        @(posedge i_clock);
        i_external_reset_n <= 1'b0;
        repeat (6) @(posedge i_clock);
        i_external_reset_n <= 1'b1;
        repeat (6) @(posedge i_clock);
    endtask : ext_rst
    // waits one timeout: 2048 ticks of 8 clocks
    task automatic wait_for(input logic sys, input logic rs);
        int n;
        n = 0;
        if (rs) restart();
        while ((sys ? o_system_reset : o_interrupt_request) !== 1'b1 && n < 16484) begin
            @(negedge i_clock);
            n++;
        end
        chk(n > 16300 && n < 16484, "timeout length");
    endtask : wait_for
    always @(posedge i_clock) begin
        if (rd_seen) begin
            note = exp_q.pop_front();
            chk((o_read_data & note[15:8]) === note[7:0], "read data mismatch");
        end
        if (o_system_reset === 1'b1) rst_cnt++;
        rd_seen <= i_read;
    end
    initial begin
        #950000;
        n_mismatch++;
        test_done();
    end
    initial begin
        void'($urandom(32'h5BB78DD2));
        repeat (8) @(posedge i_clock);
        i_reset <= 1'b0;
        rd(CS, 8'hFF, CONTROL_RESET);
        rd(RC, 8'h0F, 8'h01);
        ext_rst();
        rd(RC, 8'h0F, 8'h03);
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clock);
        i_reset <= 1'b0;
        rd(RC, 8'h0F, 8'h01);
        wr(RC, 8'h00);
        ext_rst();
        rd(RC, 8'h0F, 8'h02);
        wr(CS, 8'h08);
        wr(CS, 8'h18);
        rd(CS, 8'h10, 8'h10);
        repeat (3) @(posedge i_clock);
        wr(CS, 8'h07);
        rd(CS, 8'h1F, 8'h08);
        repeat (3) begin
            pd = {2'b00, 1'($urandom()), 2'b00, 3'($urandom())};
            wr(CS, 8'h18);
            wr(CS, pd);
            rd(CS, 8'hFF, pd);
        end
        wr(CS, 8'h18);
        wr(CS, 8'h00);
        i_global_interrupt_enable <= 1'b1;
        wr(CS, 8'h40);
        wait_for(1'b0, 1'b1);
        rd(CS, 8'hC8, 8'hC0);
        i_global_interrupt_enable <= 1'b0;
        repeat (2) @(negedge i_clock);
        chk(o_interrupt_request === 1'b0, "request not masked");
        wr(CS, 8'hC0);
        rd(CS, 8'hC8, 8'h40);
        i_global_interrupt_enable <= 1'b1;
        wr(CS, 8'h48);
        wait_for(1'b0, 1'b1);
        wait_for(1'b1, 1'b0);
        rd(RC, 8'h08, 8'h08);
        wr(CS, 8'h18);
        wr(CS, 8'h00);
        rd(CS, 8'hFF, 8'h08);
        wr(RC, 8'h00);
        wr(CS, 8'h18);
        wr(CS, 8'h00);
        rd(CS, 8'hFF, 8'h00);
        wr(CS, 8'h48);
        wait_for(1'b0, 1'b1);
        vec();
        rd(CS, 8'hC8, 8'h08);
        wr(CS, 8'h48);
        rd(CS, 8'hC8, 8'h48);
        c = rst_cnt;
        repeat (21) begin
            repeat (800) @(posedge i_clock);
            restart();
        end
        chk(rst_cnt == c, "reset despite restart");
        i_always_on_fuse <= 1'b0;
        repeat (6) @(posedge i_clock);
        wr(CS, 8'h40);
        rd(CS, 8'h48, 8'h08);
        repeat (2) @(posedge i_clock);
        test_done();
    end
endmodule : watchdog_control_tb_top
`default_nettype wire
